// file: dv/data_clock_timing_chain_tb_top.sv
// Purpose: run chain and processor end against each other
// Assumes: oscillator pins sped up so one bit period is 40000 cycles on the coarse source, 400000 on the fine source
// Notes: coarse and fine pins period 4 cycles, ext_ref period 20
`default_nettype none
module data_clock_timing_chain_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fine_osc = 1'b0;
  logic coarse_osc = 1'b0;
  logic ext_ref = 1'b0;
  logic ext_connected = 1'b1;
  logic data_lock = 1'b0;
  logic code_mark = 1'b1;
  logic fine_clamp, rel_p, samp_p, start_p, end_p, fine_sw, coarse_sw, ext_sw, ext_square;
  logic ext_pd;
  logic time_code;
  logic [7:0] time_code_level;
  logic [15:0] ms_count;
  int bad_count = 0;
  int samples_checked = 0;
  dct_if lnk ();
  always #4 core_clk = ~core_clk;
  dct_chain dct_chain_i (.core_clk(core_clk), .rst_b(rst_b), .fine_osc(fine_osc),
    .coarse_osc(coarse_osc), .ext_ref(ext_ref), .ext_connected(ext_connected), .lnk(lnk),
    .fine_clamp(fine_clamp), .fine_clamp_release_pulse(rel_p), .fine_sample_pulse(samp_p),
    .bit_start_pulse(start_p), .bit_end_sample_pulse(end_p), .fine_sw(fine_sw),
    .coarse_sw(coarse_sw), .ext_sw(ext_sw), .ext_square(ext_square), .ext_pd(ext_pd));
  dct_cpu dct_cpu_i (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk), .data_lock(data_lock),
    .code_mark(code_mark), .time_code(time_code), .time_code_level(time_code_level),
    .ms_count(ms_count));
  dct_link_monitor dct_link_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
    .proc_clk(lnk.proc_clk), .tick_1k(lnk.tick_1k), .tick_100(lnk.tick_100),
    .carrier_level(lnk.carrier_level), .ext_present(lnk.ext_present),
    .loop_sel(lnk.loop_sel), .coarse_sel(lnk.coarse_sel));
  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_ev(input int which, input int lim, output int n);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < lim) begin
      step(1);
      n++;
      case (which)
        0: hit = (start_p === 1'b1);
        1: hit = (rel_p === 1'b1);
        2: hit = (samp_p === 1'b1);
        default: hit = (end_p === 1'b1);
      endcase
    end
    check("event seen", 16'h1, {15'h0, hit});
  endtask
  task automatic clk_rises(input int cycles, output int n);
    logic p;
    n = 0;
    p = lnk.proc_clk;
    repeat (cycles) begin
      step(1);
      n += (lnk.proc_clk === 1'b1 && p === 1'b0);
      p = lnk.proc_clk;
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset_state;
    int n;
    step(10);
    check("coarse_sel", 16'h1, {15'h0, lnk.coarse_sel});
    check("fine_sw", 16'h0, {15'h0, fine_sw});
    check("fine_clamp", 16'h1, {15'h0, fine_clamp});
    check("ext_present", 16'h1, {15'h0, lnk.ext_present});
    check("ext_sw", 16'h0, {15'h0, ext_sw});
    clk_rises(40, n);
    check("proc_clk coarse rises", 16'd10, n[15:0]);
  endtask
  task automatic t_code_level;
    logic [7:0] c;
    step(1);
    c = lnk.carrier_level;
    step(1);
    check("mark level", {8'h0, c}, {8'h0, time_code_level});
    code_mark = 1'b0;
    step(3);
    c = lnk.carrier_level;
    step(1);
    check("space level", {8'h0, {2'b0, c[7:2]} + 8'h60}, {8'h0, time_code_level});
    check("time_code", 16'h0, {15'h0, time_code});
  endtask
  task automatic t_ext_square;
    int hi;
    int pd_hi;
    int pd_rises;
    logic p;
    hi = 0;
    pd_hi = 0;
    pd_rises = 0;
    p = ext_pd;
    repeat (400) begin
      step(1);
      hi += (ext_square === 1'b1);
      pd_hi += (ext_pd === 1'b1);
      pd_rises += (ext_pd === 1'b1 && p === 1'b0);
      p = ext_pd;
    end
    check("ext_square high", 16'd200, hi[15:0]);
    check("ext_pd sets", 16'd1, pd_rises[15:0]);
    check("ext_pd clears", 16'h1, {15'h0, pd_hi > 0 && pd_hi <= 41});
  endtask
  task automatic t_bit_timing;
    int n;
    wait_ev(0, 50000, n);
    check("tick_100 at start", 16'h1, {15'h0, lnk.tick_100});
    check("clamp at start", 16'h1, {15'h0, fine_clamp});
    wait_ev(1, 20000, n);
    check("to release", 16'd18000, n[15:0]);
    check("clamp released", 16'h0, {15'h0, fine_clamp});
    check("coarse_sw in acq", 16'h1, {15'h0, coarse_sw});
    check("fine_sw in acq", 16'h0, {15'h0, fine_sw});
    wait_ev(2, 5000, n);
    check("to fine sample", 16'd4000, n[15:0]);
    wait_ev(3, 17000, n);
    check("to end sample", 16'd16000, n[15:0]);
    check("ms_count", 16'd19, ms_count);
  endtask
  task automatic t_track;
    int n;
    data_lock = 1'b1;
    wait_ev(0, 3000, n);
    check("end to start", 16'd2000, n[15:0]);
    step(12);
    check("loop fine", {14'h0, dct_pkg::LOOP_FINE}, {14'h0, lnk.loop_sel});
    check("coarse off", 16'h0, {15'h0, lnk.coarse_sel});
    check("fine_sw on", 16'h1, {15'h0, fine_sw});
    check("coarse_sw off", 16'h0, {15'h0, coarse_sw});
    clk_rises(80, n);
    check("proc_clk rises", 16'd10, n[15:0]);
  endtask
  // ****
  // stimulus and sequence
  // ****
  initial forever begin
    repeat (2) @(posedge core_clk);
    #1;
    fine_osc = ~fine_osc;
    coarse_osc = ~coarse_osc;
  end
  initial forever begin
    repeat (10) @(posedge core_clk);
    #1;
    ext_ref = ~ext_ref;
  end
  initial begin
    #800000;
    bad_count++;
    wrap_up();
  end
  initial begin
    step(20);
    rst_b = 1'b1;
    t_reset_state();
    t_code_level();
    t_ext_square();
    t_bit_timing();
    t_track();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: dv/dct_link_monitor.sv
// Purpose: watch the link between chain and processor end
// Assumes: one clock domain, rst_b active low
// Notes: inputs mirror dct_if signals
`default_nettype none
module dct_link_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link
  input wire logic proc_clk,
  input wire logic tick_1k,
  input wire logic tick_100,
  input wire logic [7:0] carrier_level,
  input wire logic ext_present,
  input wire dct_pkg::dct_loop_e loop_sel,
  input wire logic coarse_sel
);
  // ****
  // ms counter between 100 Hz ticks
  // ****
  logic [3:0] ms_since_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ms_since_q <= 4'h0;
    else if (tick_100) ms_since_q <= 4'h0;
    else if (tick_1k) ms_since_q <= ms_since_q + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ****
  // checks
  // ****
  chk_tick_spacing_ms: assert property (tick_1k |=> !tick_1k [*8])
    else $error("tick_1k pulses too close");
  chk_hundred_with_ms: assert property (tick_100 |-> tick_1k)
    else $error("tick_100 without tick_1k");
  chk_hundred_count: assert property (tick_100 |-> ms_since_q == 4'h9)
    else $error("tick_100 not on tenth ms");
  chk_ext_needs_present: assert property (loop_sel == dct_pkg::LOOP_EXT |-> ext_present)
    else $error("external loop without reference");
  chk_coarse_on_tick: assert property ($changed(coarse_sel) |-> $past(tick_100))
    else $error("coarse_sel moved off tick_100");
  chk_coarse_not_fine: assert property (
    coarse_sel |-> !(loop_sel inside {dct_pkg::LOOP_FINE, dct_pkg::LOOP_EXT}))
    else $error("coarse timebase with fine loop");
  chk_carrier_ms_start: assert property (tick_1k |=> carrier_level == 8'h80)
    else $error("carrier not at step zero");
  chk_carrier_step_hold: assert property ($changed(carrier_level) |=> $stable(carrier_level) [*8])
    else $error("carrier step too short");
endmodule
`default_nettype wire

// file: rtl/dct_chain.sv
// Purpose: data clock dividers, bit timing pulses and loop input switches
// Assumes: oscillator and reference pins far slower than core_clk
// Notes: every pin passes two flip-flops before use
`default_nettype none
module dct_chain (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // oscillator and reference pins
  input wire logic fine_osc,
  input wire logic coarse_osc,
  input wire logic ext_ref,
  input wire logic ext_connected,
  // processor link
  dct_if.chain lnk,
  // analog board controls
  output logic fine_clamp,
  output logic fine_clamp_release_pulse,
  output logic fine_sample_pulse,
  output logic bit_start_pulse,
  output logic bit_end_sample_pulse,
  output logic fine_sw,
  output logic coarse_sw,
  output logic ext_sw,
  output logic ext_square,
  output logic ext_pd
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  // pin order: fine, coarse, ext reference, ext connected
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;
  logic [2:0] pin_p_q;
  assign pin_raw = {ext_connected, ext_ref, coarse_osc, fine_osc};
  for (genvar gi = 0; gi < 4; gi = gi + 1) begin : g_pin
    logic [1:0] sync_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_q <= 2'h0;
      end else begin
        sync_q <= {sync_q[0], pin_raw[gi]};
      end
    end
    assign pin_sync[gi] = sync_q[1];
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_p_q <= 3'h0;
    end else begin
      pin_p_q <= pin_sync[2:0];
    end
  end
  wire [2:0] pin_rise = pin_sync[2:0] & ~pin_p_q;
  wire fine_rise = pin_rise[0];
  wire coarse_rise = pin_rise[1];
  wire ext_rise = pin_rise[2];
  wire coarse_lvl = pin_sync[1];
  wire conn_lvl = pin_sync[3];
  // ****************************************
  // fine oscillator dividers
  // ****************************************
  logic fine_half_q;
  logic [3:0] fine_div_q;
  wire fine_div_end = fine_rise && (fine_div_q == dct_pkg::FINE_CHAIN_DIV - 4'h1);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_half_q <= 1'b0;
      fine_div_q <= 4'h0;
    end else if (fine_rise) begin
      fine_half_q <= ~fine_half_q;
      fine_div_q <= fine_div_end ? 4'h0 : fine_div_q + 4'h1;
    end
  end
  // ****************************************
  // source selection
  // ****************************************
  wire src_tick = lnk.coarse_sel ? coarse_rise : fine_div_end;
  wire proc_clk_d = lnk.coarse_sel ? coarse_lvl : fine_half_q;
  // ****************************************
  // timing chain
  // ****************************************
  logic [6:0] div100_q;
  logic [3:0] step_q, msdiv_q;
  wire tick_10k = src_tick && (div100_q == dct_pkg::TICK_10K_DIV - 7'h1);
  wire tick_1k = tick_10k && (step_q == dct_pkg::TICK_1K_DIV - 4'h1);
  wire tick_100 = tick_1k && (msdiv_q == dct_pkg::TICK_100_DIV - 4'h1);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div100_q <= 7'h0;
      step_q <= 4'h0;
      msdiv_q <= 4'h0;
    end else begin
      if (src_tick) begin
        div100_q <= tick_10k ? 7'h0 : div100_q + 7'h1;
      end
      if (tick_10k) begin
        step_q <= tick_1k ? 4'h0 : step_q + 4'h1;
      end
      if (tick_1k) begin
        msdiv_q <= tick_100 ? 4'h0 : msdiv_q + 4'h1;
      end
    end
  end
  // ****************************************
  // bit period pulse decode
  // ****************************************
  // step entering the half point of one ms division
  function automatic logic half_point(input logic [3:0] step, input logic [3:0] ms,
      input logic [3:0] want);
    half_point = (step == dct_pkg::HALF_STEP - 4'h1) && (ms == want);
  endfunction
  wire at_start = tick_10k && (step_q == dct_pkg::TICK_1K_DIV - 4'h1) &&
                  (msdiv_q == dct_pkg::TICK_100_DIV - 4'h1);
  wire at_release = tick_10k && half_point(step_q, msdiv_q, dct_pkg::CLAMP_REL_DIV);
  wire at_fsample = tick_10k && half_point(step_q, msdiv_q, dct_pkg::FINE_SAMPLE_DIV);
  wire at_end = tick_10k && half_point(step_q, msdiv_q, dct_pkg::END_SAMPLE_DIV);
  // ****************************************
  // loop input switches
  // ****************************************
  wire sel_fine = (lnk.loop_sel == dct_pkg::LOOP_FINE);
  wire sel_coarse = (lnk.loop_sel == dct_pkg::LOOP_COARSE);
  wire sel_ext = (lnk.loop_sel == dct_pkg::LOOP_EXT) && conn_lvl;
  // ****************************************
  // link outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk.proc_clk <= 1'b0;
      lnk.tick_1k <= 1'b0;
      lnk.tick_100 <= 1'b0;
      lnk.carrier_level <= dct_pkg::CARRIER_MID;
      lnk.ext_present <= 1'b0;
    end else begin
      lnk.proc_clk <= proc_clk_d;
      lnk.tick_1k <= tick_1k;
      lnk.tick_100 <= tick_100;
      lnk.carrier_level <= dct_pkg::sine_step(step_q);
      lnk.ext_present <= conn_lvl;
    end
  end
  // ****************************************
  // bit period pulses
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_clamp <= 1'b1;
      fine_clamp_release_pulse <= 1'b0;
      fine_sample_pulse <= 1'b0;
      bit_start_pulse <= 1'b0;
      bit_end_sample_pulse <= 1'b0;
    end else begin
      if (at_start) begin
        fine_clamp <= 1'b1;
      end else if (at_release) begin
        fine_clamp <= 1'b0;
      end
      fine_clamp_release_pulse <= at_release;
      fine_sample_pulse <= at_fsample;
      bit_start_pulse <= at_start;
      bit_end_sample_pulse <= at_end;
    end
  end
  // ****************************************
  // loop switch outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_sw <= 1'b0;
      coarse_sw <= 1'b0;
      ext_sw <= 1'b0;
    end else begin
      fine_sw <= sel_fine;
      coarse_sw <= sel_coarse;
      ext_sw <= sel_ext;
    end
  end
  // ****************************************
  // external reference detector
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_square <= 1'b0;
      ext_pd <= 1'b0;
    end else begin
      if (ext_rise) begin
        ext_square <= ~ext_square;
      end
      if (tick_10k) begin
        ext_pd <= 1'b1;
      end else if (ext_rise && !ext_square) begin
        ext_pd <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/dct_cpu.sv
// Purpose: processor end choosing loop sources and modulating the time code
// Assumes: lock and code inputs come from logic on core_clk
// Notes: decisions taken on the 100 Hz tick
`default_nettype none
module dct_cpu (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // chain link
  dct_if.cpu lnk,
  // processor side status and code
  input wire logic data_lock,
  input wire logic code_mark,
  output logic time_code,
  output logic [7:0] time_code_level,
  output logic [15:0] ms_count
);
  // ****************************************
  // lock state machine
  // ****************************************
  typedef enum logic [1:0] {
    ST_ACQ,
    ST_TRACK,
    ST_FREEZE,
    ST_RELOCK
  } dct_cpu_st_e;
  dct_cpu_st_e st_q, st_d;
  logic [7:0] lost_q;
  wire lost_long = (lost_q >= dct_pkg::LOST_LIMIT);
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_ACQ: st_d = data_lock ? ST_TRACK : ST_ACQ;
      ST_TRACK: st_d = data_lock ? ST_TRACK : ST_FREEZE;
      ST_FREEZE: st_d = data_lock ? ST_TRACK : (lost_long ? ST_RELOCK : ST_FREEZE);
      ST_RELOCK: st_d = data_lock ? ST_TRACK : ST_RELOCK;
      default: st_d = ST_ACQ;
    endcase
  end
  // ****************************************
  // loop source decode
  // ****************************************
  dct_pkg::dct_loop_e loop_d;
  always_comb begin
    case (st_d)
      ST_TRACK: loop_d = dct_pkg::LOOP_FINE;
      ST_FREEZE: loop_d = lnk.ext_present ? dct_pkg::LOOP_EXT : dct_pkg::LOOP_OPEN;
      default: loop_d = dct_pkg::LOOP_COARSE;
    endcase
  end
  wire [7:0] space_level = {2'h0, lnk.carrier_level[7:2]} + dct_pkg::SPACE_OFFSET;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_ACQ;
      lost_q <= 8'h00;
      lnk.loop_sel <= dct_pkg::LOOP_OPEN;
      lnk.coarse_sel <= 1'b1;
      time_code <= 1'b0;
      time_code_level <= dct_pkg::CARRIER_MID;
      ms_count <= 16'h0000;
    end else begin
      if (lnk.tick_100) begin
        st_q <= st_d;
        lnk.loop_sel <= loop_d;
        lnk.coarse_sel <= (st_d == ST_ACQ);
        if (st_d == ST_FREEZE) begin
          lost_q <= lost_long ? lost_q : lost_q + 8'h01;
        end else begin
          lost_q <= 8'h00;
        end
      end
      if (lnk.tick_1k) begin
        ms_count <= ms_count + 16'h0001;
      end
      time_code <= code_mark;
      time_code_level <= code_mark ? lnk.carrier_level : space_level;
    end
  end
endmodule
`default_nettype wire

// file: rtl/dct_if.sv
// Purpose: link between the timing chain and the processor end
// Assumes: both ends on core_clk
// Notes: ticks are one-cycle pulses, selections are levels
`default_nettype none
interface dct_if;
  logic proc_clk;
  logic tick_1k;
  logic tick_100;
  logic [7:0] carrier_level;
  logic ext_present;
  dct_pkg::dct_loop_e loop_sel;
  logic coarse_sel;
  modport chain (
    output proc_clk,
    output tick_1k,
    output tick_100,
    output carrier_level,
    output ext_present,
    input loop_sel,
    input coarse_sel
  );
  modport cpu (
    input proc_clk,
    input tick_1k,
    input tick_100,
    input carrier_level,
    input ext_present,
    output loop_sel,
    output coarse_sel
  );
endinterface
`default_nettype wire

// file: rtl/dct_pkg.sv
// Purpose: shared constants for the data clock timing chain and its processor end
// Assumes: one core clock at 125 MHz, oscillators arrive as slow pin levels
// Notes: divider counts, pulse positions and carrier steps live here
`default_nettype none
package dct_pkg;
  // ****************************************
  // divider ratios
  // ****************************************
  localparam logic [3:0] FINE_CHAIN_DIV = 4'ha;
  localparam logic [6:0] TICK_10K_DIV = 7'h64;
  localparam logic [3:0] TICK_1K_DIV = 4'ha;
  localparam logic [3:0] TICK_100_DIV = 4'ha;
  // ****************************************
  // bit period positions (ms division, 100 us step)
  // ****************************************
  localparam logic [3:0] HALF_STEP = 4'h5;
  localparam logic [3:0] BIT_START_DIV = 4'h0;
  localparam logic [3:0] CLAMP_REL_DIV = 4'h4;
  localparam logic [3:0] FINE_SAMPLE_DIV = 4'h5;
  localparam logic [3:0] END_SAMPLE_DIV = 4'h9;
  // ****************************************
  // processor side timing
  // ****************************************
  localparam logic [7:0] LOST_LIMIT = 8'hc8;
  localparam logic [7:0] CARRIER_MID = 8'h80;
  localparam logic [7:0] SPACE_OFFSET = 8'h60;
  // ****************************************
  // loop input selection
  // ****************************************
  typedef enum logic [1:0] {
    LOOP_OPEN,
    LOOP_FINE,
    LOOP_COARSE,
    LOOP_EXT
  } dct_loop_e;
  // stepwise sine level for one step of the 1 kHz carrier
  function automatic logic [7:0] sine_step(input logic [3:0] step);
    case (step)
      4'h0: sine_step = 8'h80;
      4'h1: sine_step = 8'hcb;
      4'h2: sine_step = 8'hf9;
      4'h3: sine_step = 8'hf9;
      4'h4: sine_step = 8'hcb;
      4'h5: sine_step = 8'h80;
      4'h6: sine_step = 8'h35;
      4'h7: sine_step = 8'h07;
      4'h8: sine_step = 8'h07;
      4'h9: sine_step = 8'h35;
      default: sine_step = 8'h80;
    endcase
  endfunction
endpackage
`default_nettype wire
